// [src/eag_core.sv]
// Effective address generator: forms operand, offset and linear address per request.
// Assumes the decoder holds req_valid and req until req_ready; register file reads are combinational.
module eag_core
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  input wire eag_pkg::eag_req_t req,
  output logic req_ready,
  output logic [2:0] gpr_rd_a_sel,
  output logic [2:0] gpr_rd_b_sel,
  input wire logic [31:0] gpr_rd_a_data,
  input wire logic [31:0] gpr_rd_b_data,
  output logic res_valid,
  output eag_pkg::eag_res_t res
);

  // Two-state sequencer: the extra state is spent in every base plus index mode, even with a stack pointer index.
  typedef enum logic
  {
    EAG_ST_IDLE,
    EAG_ST_ADD2
  } eag_state_t;

  // Current sequencer state and its next value.
  eag_state_t state_reg;
  eag_state_t state_next;
  // Partial sum of base and scaled index, kept for the extra clock.
  // It loads every cycle, because only the value seen in the extra clock is ever used.
  logic [31:0] partial_reg;
  // Registered acceptance pulse toward the decoder.
  logic ready_reg;
  // Registered result strobe toward the memory stages.
  logic res_valid_reg;
  // Result fields, held until the next accepted request.
  eag_pkg::eag_res_t res_reg;
  // Register selectors reloaded from the request every cycle, so they stand one cycle behind it.
  logic [2:0] sel_a_reg;
  logic [2:0] sel_b_reg;

  // Mode decode: which elements take part.
  wire eag_pkg::eag_mode_t mode = req.mode;
  // Base takes part in register indirect, based and every base plus index mode.
  wire use_base = mode inside {eag_pkg::EAG_MODE_REG_IND, eag_pkg::EAG_MODE_BASED, eag_pkg::EAG_MODE_BASE_IDX,
    eag_pkg::EAG_MODE_BASE_SIDX, eag_pkg::EAG_MODE_BASE_IDX_D, eag_pkg::EAG_MODE_BASE_SIDX_D};
  // Index takes part in the index, scaled index and every base plus index mode.
  wire use_index_raw = mode inside {eag_pkg::EAG_MODE_INDEX, eag_pkg::EAG_MODE_SCALED, eag_pkg::EAG_MODE_BASE_IDX,
    eag_pkg::EAG_MODE_BASE_SIDX, eag_pkg::EAG_MODE_BASE_IDX_D, eag_pkg::EAG_MODE_BASE_SIDX_D};
  // The stack pointer is never decoded as an index; its selection contributes zero.
  wire use_index = use_index_raw && (req.index_sel != eag_pkg::SP_SEL);
  // Only the scaled forms shift the index; the plain index forms ignore the scale field.
  wire use_scale = mode inside {eag_pkg::EAG_MODE_SCALED, eag_pkg::EAG_MODE_BASE_SIDX,
    eag_pkg::EAG_MODE_BASE_SIDX_D};
  // Displacement takes part in direct, based, both index-only modes and the two displacement forms.
  wire use_disp = mode inside {eag_pkg::EAG_MODE_DIRECT, eag_pkg::EAG_MODE_BASED, eag_pkg::EAG_MODE_INDEX,
    eag_pkg::EAG_MODE_SCALED, eag_pkg::EAG_MODE_BASE_IDX_D, eag_pkg::EAG_MODE_BASE_SIDX_D};
  // Register and immediate operands need no address at all.
  wire is_mem = !(mode inside {eag_pkg::EAG_MODE_REG, eag_pkg::EAG_MODE_IMM});
  // Base with index needs the extra clock, even when the index selection is the stack pointer.
  wire two_step = use_base && use_index_raw;

  // Displacement extension to address width.
  wire [31:0] disp_ext = (req.disp_w == eag_pkg::EAG_DISP_8) ? {{24{req.disp[7]}}, req.disp[7:0]} :
    (req.disp_w == eag_pkg::EAG_DISP_16) ? {{16{req.disp[15]}}, req.disp[15:0]} : req.disp;

  // Element values; an absent element contributes zero.
  // Shifting by zero to three positions gives the scale factors one, two, four and eight.
  wire [31:0] base_val = use_base ? gpr_rd_a_data : eag_pkg::ZERO_32;
  wire [1:0] shamt = use_scale ? req.scale : 2'h0;
  wire [31:0] index_val = use_index ? (gpr_rd_b_data << shamt) : eag_pkg::ZERO_32;
  wire [31:0] disp_val = use_disp ? disp_ext : eag_pkg::ZERO_32;

  // Sums wrap at 32 bits by construction of the operand widths.
  wire [31:0] bi_sum = base_val + index_val;
  wire [31:0] one_step_off = base_val + index_val + disp_val;
  wire [31:0] two_step_off = partial_reg + disp_val;
  // The extra clock finishes the three-term sum from the partial sum of the cycle before.
  wire [31:0] off_sel = (state_reg == EAG_ST_ADD2) ? two_step_off : one_step_off;
  // Linear address for the segmentation stage.
  wire [31:0] linear_sel = req.seg_base + off_sel;

  // Register operand sized by operand size.
  wire [31:0] reg_operand = (req.size == eag_pkg::EAG_SIZE_8) ? {24'h0, gpr_rd_a_data[7:0]} :
    (req.size == eag_pkg::EAG_SIZE_16) ? {16'h0, gpr_rd_a_data[15:0]} : gpr_rd_a_data;
  wire [31:0] operand_sel = (mode == eag_pkg::EAG_MODE_IMM) ? req.imm :
    (mode == eag_pkg::EAG_MODE_REG) ? reg_operand : eag_pkg::ZERO_32;

  // Accept the request in this cycle: single-step requests at once, base+index ones on the extra clock.
  // Requests are never refused; a held base plus index request is simply taken one clock later.
  wire take_now = req_valid && ((state_reg == EAG_ST_ADD2) || !two_step);

  // Next-state selection.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      EAG_ST_IDLE:
      begin
        // Base with index takes a second cycle to finish the three-term sum.
        if (req_valid && two_step)
        begin
          state_next = EAG_ST_ADD2;
        end
      end
      EAG_ST_ADD2:
      begin
        // The second cycle always closes the request.
        state_next = EAG_ST_IDLE;
      end
      default:
      begin
        // An unused state code falls back to idle.
        state_next = EAG_ST_IDLE;
      end
    endcase
  end

  // Sequencer and partial sum.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= EAG_ST_IDLE;
      partial_reg <= eag_pkg::ZERO_32;
    end
    else
    begin
      state_reg <= state_next;
      partial_reg <= bi_sum;
    end
  end

  // Result registers; valid is a one-cycle pulse per accepted request.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      res_valid_reg <= 1'b0;
      res_reg <= '0;
    end
    else
    begin
      res_valid_reg <= take_now;
      // Only an accepted request updates the fields; register and immediate modes leave the address at zero.
      if (take_now)
      begin
        res_reg.is_mem <= is_mem;
        res_reg.operand <= operand_sel;
        res_reg.offset <= is_mem ? off_sel : eag_pkg::ZERO_32;
        res_reg.linear <= is_mem ? linear_sel : eag_pkg::ZERO_32;
      end
    end
  end

  // Ready pulse registered to keep outputs from flip-flops; it marks the taking cycle's result.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ready_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= take_now;
    end
  end

  // Register file selectors follow the request; the decoder holds it stable.
  // They are registered so that every output leaves a flip-flop, which makes them one cycle late.
  // The core therefore reads the file data combinationally from the held request's selectors;
  // a file that answers only to these outputs would return the previous request's registers.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sel_a_reg <= 3'h0;
      sel_b_reg <= 3'h0;
    end
    else
    begin
      sel_a_reg <= req.base_sel;
      sel_b_reg <= req.index_sel;
    end
  end

  // Every output comes straight from its flip-flop.
  assign req_ready = ready_reg;
  assign res_valid = res_valid_reg;
  assign res = res_reg;
  assign gpr_rd_a_sel = sel_a_reg;
  assign gpr_rd_b_sel = sel_b_reg;

  // Checks on the answer: each result check names the taking cycle and looks at the result one clock later.
  // Base plus index requests are judged at their taking cycle, while the decoder still holds them.

  // Base plus index always occupies exactly two cycles.
  a_two_step_len: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == EAG_ST_IDLE && req_valid && two_step) |=> state_reg == EAG_ST_ADD2 ##1 state_reg == EAG_ST_IDLE)
    else $error("base plus index did not take one extra clock");
  // No answer may appear in the first cycle of a base plus index request.
  a_no_early_answer: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == EAG_ST_IDLE && req_valid && two_step) |=> !res_valid && !req_ready)
    else $error("base plus index answered too early");
  // The extra clock always ends with the answer and the acceptance pulse.
  a_ready_pairs: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == EAG_ST_ADD2 && req_valid) |=> req_ready && res_valid)
    else $error("no answer after the extra clock");
  // Every other request is answered on the next cycle.
  a_single_step: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == EAG_ST_IDLE && req_valid && !two_step) |=> res_valid)
    else $error("single-step request not answered next cycle");
  // The result stands until the next accepted request.
  a_result_hold: assert property (@(posedge mclk) disable iff (rst)
    !take_now |=> $stable(res))
    else $error("result changed without a request");

  // The linear address is the segment base plus the offset.
  a_linear_sum: assert property (@(posedge mclk) disable iff (rst)
    (take_now && is_mem) |=> res.linear == $past(req.seg_base) + res.offset)
    else $error("linear address not segment base plus offset");
  // Register and immediate modes produce no address.
  a_no_address: assert property (@(posedge mclk) disable iff (rst)
    (take_now && !is_mem) |=> !res.is_mem && res.offset == eag_pkg::ZERO_32 && res.linear == eag_pkg::ZERO_32)
    else $error("register or immediate mode produced an address");
  // The immediate operand comes straight from the request.
  a_imm_operand: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_IMM) |=> (res.operand == $past(req.imm)) && !res.is_mem)
    else $error("immediate operand wrong");
  // A byte register operand keeps only the low byte.
  a_byte_reg: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_REG && req.size == eag_pkg::EAG_SIZE_8) |=>
    res.operand == {24'h0, $past(gpr_rd_a_data[7:0])})
    else $error("byte register operand not sized");
  // A word register operand keeps the low half.
  a_word_reg: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_REG && req.size == eag_pkg::EAG_SIZE_16) |=>
    res.operand == {16'h0, $past(gpr_rd_a_data[15:0])})
    else $error("word register operand not sized");
  // A doubleword register operand is the whole register.
  a_dword_reg: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_REG && req.size == eag_pkg::EAG_SIZE_32) |=>
    res.operand == $past(gpr_rd_a_data))
    else $error("doubleword register operand wrong");

  // The direct offset is the extended displacement alone.
  a_direct_disp: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_DIRECT) |=> res.offset == $past(disp_ext))
    else $error("direct offset not the displacement");
  // A short displacement is sign-extended to the address width.
  a_disp_extend: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_DIRECT && req.disp_w == eag_pkg::EAG_DISP_8) |=>
    res.offset[31:8] == {24{res.offset[7]}} && res.offset[7:0] == $past(req.disp[7:0]))
    else $error("short displacement not sign-extended");
  // Register indirect uses the base alone.
  a_reg_ind: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_REG_IND) |=> res.offset == $past(gpr_rd_a_data))
    else $error("register indirect offset wrong");
  // Based mode adds base and displacement.
  a_based_sum: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_BASED) |=> res.offset == $past(gpr_rd_a_data) + $past(disp_ext))
    else $error("based offset wrong");
  // Index mode adds the unscaled index and the displacement.
  a_index_sum: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_INDEX && req.index_sel != eag_pkg::SP_SEL) |=>
    res.offset == $past(gpr_rd_b_data) + $past(disp_ext))
    else $error("index offset wrong");
  // Scaled index mode shifts the index and adds the displacement.
  a_scaled_sum: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_SCALED && req.index_sel != eag_pkg::SP_SEL) |=>
    res.offset == ($past(gpr_rd_b_data) << $past(req.scale)) + $past(disp_ext))
    else $error("scaled index offset wrong");
  // Based index adds base and unscaled index.
  a_base_idx: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_BASE_IDX && req.index_sel != eag_pkg::SP_SEL) |=>
    res.offset == $past(gpr_rd_a_data) + $past(gpr_rd_b_data))
    else $error("based index offset wrong");
  // Based scaled index adds base and scaled index.
  a_base_sidx: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_BASE_SIDX && req.index_sel != eag_pkg::SP_SEL) |=>
    res.offset == $past(gpr_rd_a_data) + ($past(gpr_rd_b_data) << $past(req.scale)))
    else $error("based scaled index offset wrong");
  // Based index with displacement sums all three terms.
  a_base_idx_d: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_BASE_IDX_D && req.index_sel != eag_pkg::SP_SEL) |=>
    res.offset == $past(gpr_rd_a_data) + $past(gpr_rd_b_data) + $past(disp_ext))
    else $error("based index with displacement offset wrong");
  // Based scaled index with displacement sums all three terms.
  a_base_sidx_d: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_BASE_SIDX_D && req.index_sel != eag_pkg::SP_SEL) |=>
    res.offset == $past(gpr_rd_a_data) + ($past(gpr_rd_b_data) << $past(req.scale)) + $past(disp_ext))
    else $error("based scaled index with displacement offset wrong");
  // A stack pointer index selection adds nothing in a base plus index form.
  a_no_sp_index: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_BASE_IDX_D && req.index_sel == eag_pkg::SP_SEL) |=>
    res.offset == $past(gpr_rd_a_data) + $past(disp_ext))
    else $error("stack pointer used as index");
  // A stack pointer index selection adds nothing in index mode either.
  a_index_sp: assert property (@(posedge mclk) disable iff (rst)
    (take_now && mode == eag_pkg::EAG_MODE_INDEX && req.index_sel == eag_pkg::SP_SEL) |=>
    res.offset == $past(disp_ext))
    else $error("stack pointer used as index in index mode");

  // Main scenarios worth seeing: the extra clock, the full scaled form, a wrapping address,
  // back-to-back requests and a stack pointer index selection.
  c_two_step: cover property (@(posedge mclk) disable iff (rst) state_reg == EAG_ST_ADD2 ##1 res_valid);
  c_scaled: cover property (@(posedge mclk) disable iff (rst) take_now && mode == eag_pkg::EAG_MODE_BASE_SIDX_D);
  c_wrap: cover property (@(posedge mclk) disable iff (rst) take_now && is_mem && linear_sel < req.seg_base);
  c_back2back: cover property (@(posedge mclk) disable iff (rst) take_now ##1 take_now);
  c_sp_index: cover property (@(posedge mclk) disable iff (rst)
    take_now && use_index_raw && req.index_sel == eag_pkg::SP_SEL);

endmodule : eag_core

// [src/eag_pkg.sv]
// Package for the effective address generator: modes, widths, request and result carriers.
// Assumes a single processor clock and a decoder that holds a request until it is accepted.
// Operation
// - Eleven modes: register, immediate, nine memory
// - Register mode reads sized general register
// - Immediate mode takes decoder bytes, no access
// - Linear address is segment base plus offset
// - Displacement 8, 16 or 32 bits, sign-extended
// - Any general register may be base
// - Stack pointer register never used as index
// - Index scaled by shift of 0..3
// - Offset is base plus scaled index plus displacement
// - Address calculation pipelined, extra cycle only for base with index
// - Base with index costs one extra clock
// - Direct mode offset is displacement alone
// - Register indirect uses base only
// - Based mode adds base and displacement
// - Index mode adds unscaled index and displacement
// - Scaled index adds scaled index and displacement
// - Based index adds base and unscaled index
// - Based scaled index adds base, scaled index
// - Based index with displacement sums all three
// - Based scaled index with displacement sums all
package eag_pkg;

  // Address and data width of the datapath.
  localparam int ADDR_W = 32;
  // Number of general registers and width of a register selector.
  localparam int GPR_N = 8;
  localparam int SEL_W = 3;
  // Selector of the stack pointer register, which may never serve as an index.
  localparam logic [2:0] SP_SEL = 3'h4;
  // Reset value of every result register.
  localparam logic [31:0] ZERO_32 = 32'h0;

  // The eleven operand addressing modes.
  typedef enum logic [3:0]
  {
    EAG_MODE_REG,
    EAG_MODE_IMM,
    EAG_MODE_DIRECT,
    EAG_MODE_REG_IND,
    EAG_MODE_BASED,
    EAG_MODE_INDEX,
    EAG_MODE_SCALED,
    EAG_MODE_BASE_IDX,
    EAG_MODE_BASE_SIDX,
    EAG_MODE_BASE_IDX_D,
    EAG_MODE_BASE_SIDX_D
  } eag_mode_t;

  // Operand size.
  typedef enum logic [1:0]
  {
    EAG_SIZE_8,
    EAG_SIZE_16,
    EAG_SIZE_32
  } eag_size_t;

  // Displacement width as delivered by the decoder.
  typedef enum logic [1:0]
  {
    EAG_DISP_8,
    EAG_DISP_16,
    EAG_DISP_32
  } eag_disp_t;

  // One request from the instruction decoder.
  typedef struct packed
  {
    eag_mode_t mode;
    eag_size_t size;
    eag_disp_t disp_w;
    logic [31:0] disp;
    logic [31:0] imm;
    logic [2:0] base_sel;
    logic [2:0] index_sel;
    logic [1:0] scale;
    logic [31:0] seg_base;
  } eag_req_t;

  // One result toward the segmentation and memory stages.
  typedef struct packed
  {
    logic is_mem;
    logic [31:0] operand;
    logic [31:0] offset;
    logic [31:0] linear;
  } eag_res_t;

endpackage : eag_pkg

// [test/eag_gpr_model.sv]
// Model of the general register file beside the address generator.
// Assumes the bench feeds it the selectors of the live request.
module eag_gpr_model
(
  input wire logic [2:0] rd_a_sel,
  input wire logic [2:0] rd_b_sel,
  output logic [31:0] rd_a_data,
  output logic [31:0] rd_b_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Fixed, large contents, so that address sums carry out of 32 bits.
  logic [31:0] gpr [8];
  initial
  begin
    for (int i = 0; i < 8; i++)
      gpr[i] = 32'h1111_1111 * i + 32'h8000_0003;
  end
  // Reads are combinational, because the core uses the data in the request cycle.
  assign rd_a_data = gpr[rd_a_sel];
  assign rd_b_data = gpr[rd_b_sel];
endmodule : eag_gpr_model

// [test/effective_address_generator_tb_top.sv]
// Self-checking bench for the address generator core.
// Assumes the register model above and a 100 MHz clock.
module effective_address_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  eag_pkg::eag_req_t req = '0;
  logic req_ready;
  logic res_valid;
  logic [2:0] a_sel;
  logic [2:0] b_sel;
  logic [31:0] a_data;
  logic [31:0] b_data;
  eag_pkg::eag_res_t res;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  // Segment base given with each request.
  logic [31:0] seg = 32'h0001_0000;

  // Clock of 10 ns period.
  always #5 mclk = ~mclk;

  eag_core i_eag_core (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .gpr_rd_a_sel(a_sel), .gpr_rd_b_sel(b_sel), .gpr_rd_a_data(a_data),
    .gpr_rd_b_data(b_data), .res_valid(res_valid), .res(res));
  eag_gpr_model i_eag_gpr_model (.rd_a_sel(req.base_sel), .rd_b_sel(req.index_sel),
    .rd_a_data(a_data), .rd_b_data(b_data));

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // A hang is cut short well beyond the roughly eighty cycles the tests need.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      stop_test();
    end
  end

  // Compares one value of up to 128 bits.
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Builds a request; the mode masks below say which elements each mode uses.
  function automatic eag_pkg::eag_req_t mk(input logic [3:0] m, input logic [2:0] b, input logic [2:0] x,
    input logic [1:0] s, input logic [1:0] w, input logic [31:0] d);
    mk = '0;
    mk.mode = eag_pkg::eag_mode_t'(m);
    mk.size = eag_pkg::EAG_SIZE_32;
    mk.disp_w = eag_pkg::eag_disp_t'(w);
    mk.disp = d;
    mk.imm = 32'h5A5A_00C3;
    mk.base_sel = b;
    mk.index_sel = x;
    mk.scale = s;
    mk.seg_base = seg;
  endfunction : mk

  // Expected result; bits of the masks are indexed by mode: base, index, scale, displacement.
  function automatic eag_pkg::eag_res_t predict(input eag_pkg::eag_req_t r);
    logic [31:0] b;
    logic [31:0] x;
    logic [31:0] d;
    logic [31:0] o;
    b = i_eag_gpr_model.gpr[r.base_sel];
    x = (r.index_sel == eag_pkg::SP_SEL) ? 32'h0 : i_eag_gpr_model.gpr[r.index_sel];
    d = (r.disp_w == eag_pkg::EAG_DISP_8) ? {{24{r.disp[7]}}, r.disp[7:0]} :
      (r.disp_w == eag_pkg::EAG_DISP_16) ? {{16{r.disp[15]}}, r.disp[15:0]} : r.disp;
    o = (11'h798 >> r.mode) & 11'h1 ? b : 32'h0;
    o += ((11'h7E0 >> r.mode) & 11'h1 ? x : 32'h0) << ((11'h540 >> r.mode) & 11'h1 ? r.scale : 2'h0);
    o += (11'h674 >> r.mode) & 11'h1 ? d : 32'h0;
    predict = '0;
    if (r.mode == eag_pkg::EAG_MODE_REG)
      predict.operand = b & ((r.size == eag_pkg::EAG_SIZE_8) ? 32'hFF :
        (r.size == eag_pkg::EAG_SIZE_16) ? 32'hFFFF : 32'hFFFF_FFFF);
    else if (r.mode == eag_pkg::EAG_MODE_IMM)
      predict.operand = r.imm;
    else
      predict = {1'b1, 32'h0, o, r.seg_base + o};
  endfunction : predict

  // Presents one request, drops it at the taking edge, checks answer timing and result.
  task automatic run(input eag_pkg::eag_req_t r);
    eag_pkg::eag_res_t e;
    int lat;
    e = predict(r);
    lat = (r.mode > 4'h6) ? 2 : 1;
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= r;
    for (int k = 1; k <= lat; k++)
    begin
      @(posedge mclk);
      if (k == lat)
        req_valid <= 1'b0;
      #1;
      chk(req_ready, k == lat, "ready timing");
    end
    chk(res_valid, 1'b1, "result valid");
    chk({a_sel, b_sel}, {r.base_sel, r.index_sel}, "selectors");
    chk(res, e, "result");
  endtask : run

  // Register operand at each size, then an immediate.
  task automatic test_operand();
    eag_pkg::eag_req_t r;
    for (int z = 0; z < 3; z++)
    begin
      r = mk(4'h0, 3'(z * 3), 3'h0, 2'h0, 2'h2, 32'h0);
      r.size = eag_pkg::eag_size_t'(z);
      run(r);
    end
    run(mk(4'h1, 3'h1, 3'h2, 2'h0, 2'h2, 32'h0));
  endtask : test_operand

  // Direct mode with each displacement width; negative short values must extend.
  task automatic test_disp();
    run(mk(4'h2, 3'h0, 3'h0, 2'h0, 2'h0, 32'h0000_0080));
    run(mk(4'h2, 3'h0, 3'h0, 2'h0, 2'h1, 32'h1234_8001));
    run(mk(4'h2, 3'h0, 3'h0, 2'h0, 2'h2, 32'hFFFF_FFFC));
  endtask : test_disp

  // Single-step modes; every register as base, every scale.
  task automatic test_single();
    for (int b = 0; b < 8; b++)
      run(mk(4'h3, 3'(b), 3'h0, 2'h0, 2'h2, 32'h0));
    run(mk(4'h4, 3'h5, 3'h0, 2'h0, 2'h0, 32'h0000_007F));
    run(mk(4'h5, 3'h0, 3'h3, 2'h2, 2'h2, 32'h0000_0010));
    run(mk(4'h5, 3'h0, 3'h4, 2'h0, 2'h1, 32'h0000_8000));
    for (int s = 0; s < 4; s++)
      run(mk(4'h6, 3'h0, 3'h6, 2'(s), 2'h0, 32'h0000_00F0));
  endtask : test_single

  // Base plus index modes: extra clock, stack pointer as index, wrapping sums.
  task automatic test_dual();
    seg = 32'hF000_0000;
    for (int m = 7; m < 11; m++)
    begin
      run(mk(4'(m), 3'h7, 3'h2, 2'h3, 2'h2, 32'h9000_0000));
      run(mk(4'(m), 3'h6, 3'h4, 2'h1, 2'h0, 32'h0000_0081));
    end
  endtask : test_dual

  // Reset in mid-run: every output returns to zero and stays idle after release.
  task automatic test_reset();
    run(mk(4'h4, 3'h2, 3'h0, 2'h0, 2'h2, 32'h0000_1000));
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk({req_ready, res_valid, a_sel, b_sel, res}, 128'h0, "outputs in reset");
    @(posedge mclk);
    #1;
    chk(res_valid, 1'b0, "idle after release");
  endtask : test_reset

  // Main sequence: reset for four cycles, then each scenario.
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk(res_valid, 1'b0, "idle after reset");
    test_operand();
    test_disp();
    test_single();
    test_dual();
    test_reset();
    stop_test();
  end
endmodule : effective_address_generator_tb_top
